/* rtl/isb_pkg.sv */
// Shared constants for the two-wire target front end and its bus master.
// Assumes a 200 MHz system clock for the master and a free link clock
// for the target end.
// Contract
// - Target only, 7-bit address, never drives clock
// - Works at 100 and 400 kb/s
// - Master makes every clock pulse
// - Master writes and reads the wiper register
// - Data falling with clock high starts transfer
// - Data changes only while clock low
// - Acknowledge low on ninth clock
// - Wrong or general call address gets no acknowledge
// - Master restarts with Start after an error
// - Repeated Start handled exactly like Start
// - Repeated Start collision flagged, bus logic reset; code flags only a released read bit seen low, then ignores until Start
// - Data rising with clock high ends transfer
// - Stop returns interface to idle
// - Target never stretches the clock
// - Malformed transfers abandoned without state change
// - Unexpected Start or Stop aborts command
// - Glitches filtered on both bus inputs
// - Fixed address 0101110, variant 0111110
// - Invalid command: release data, ignore until addressed; code acknowledges it and its data byte, only the write is blocked
// - Static state from Stop until next Start
package isb_pkg;

  // ---------------------------------------------------------------
  // Addresses and register
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_MAIN = 7'h2E;
  localparam logic [6:0] ADDR_ALT = 7'h3E;
  localparam logic [6:0] ADDR_GENERAL_CALL = 7'h00;
  localparam logic [6:0] WIPER_RESET = 7'h3F;
  localparam logic [7:0] CMD_WIPER = 8'h00;
  localparam int BYTE_BITS = 8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int SCL_STD_HZ = 100_000;
  localparam int SCL_FAST_HZ = 400_000;
  localparam int LINK_PERIOD_PS = 6000;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYCLES =
    (SPIKE_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;

endpackage : isb_pkg

/* rtl/isb_bus_if.sv */
// Open-drain two-wire bus joining the master end and the target end.
// Assumes pull-ups: a line is low whenever any enabled driver pulls it.
`timescale 1ns/1ps
interface isb_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // ---------------------------------------------------------------
  // Wired-AND resolution
  // ---------------------------------------------------------------
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input scl,
    input sda
  );

  modport target (
    output s_sda_o,
    output s_sda_oe,
    input scl,
    input sda
  );
endinterface : isb_bus_if

/* rtl/isb_pin_filter.sv */
// Two-flop synchroniser followed by a spike filter for one bus line.
// Assumes the line idles high; output follows only stable levels.
`timescale 1ns/1ps
module isb_pin_filter #(
  parameter int FILTER_LEN = isb_pkg::SPIKE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Line
  input wire logic pin,
  output logic filt
);
  localparam int CW = $clog2(FILTER_LEN + 1);

  generate
    if (FILTER_LEN < 1) begin : g_bad_len
      $error("FILTER_LEN must be at least 1");
    end
  endgenerate

  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic filt_reg, filt_next;
  logic [CW-1:0] cnt_reg, cnt_next;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    sync1_next = pin;
    sync2_next = sync1_reg;
    filt_next = filt_reg;
    cnt_next = '0;
    // A level must hold FILTER_LEN cycles before it is believed
    if (sync2_reg != filt_reg) begin
      if (cnt_reg == CW'(FILTER_LEN - 1)) begin
        filt_next = sync2_reg;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      filt_reg <= 1'b1;
      cnt_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      filt_reg <= filt_next;
      cnt_reg <= cnt_next;
    end
  end

  assign filt = filt_reg;
endmodule : isb_pin_filter

/* rtl/isb_target.sv */
// Target end: bus front end holding the 7-bit wiper register.
// Assumes it is clocked by the free-running link clock and that the
// master keeps to standard or fast bus timing.
`timescale 1ns/1ps
module isb_target #(
  parameter logic [6:0] TARGET_ADDR = isb_pkg::ADDR_MAIN,
  parameter int FILTER_LEN = isb_pkg::SPIKE_CYCLES
) (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // Bus
  isb_bus_if.target bus,
  // User side
  output logic [6:0] wiper,
  output logic wiper_wr,
  output logic bus_active,
  output logic bus_collision
);
  generate
    if (TARGET_ADDR != isb_pkg::ADDR_MAIN &&
        TARGET_ADDR != isb_pkg::ADDR_ALT) begin : g_bad_addr
      $error("TARGET_ADDR must be one of the two product addresses");
    end
  endgenerate

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_CMD = 4'h2,
    ST_CMD_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_DATA_ACK = 4'h5,
    ST_TX = 4'h4,
    ST_MACK = 4'hC,
    ST_IGNORE = 4'hD
  } isb_tstate_type;

  // ---------------------------------------------------------------
  // Line conditioning
  // ---------------------------------------------------------------
  logic scl_f, sda_f;

  isb_pin_filter #(.FILTER_LEN(FILTER_LEN)) u_scl_filter (
    .clk(link_clk),
    .rst_n(rst_n),
    .pin(bus.scl),
    .filt(scl_f)
  );

  isb_pin_filter #(.FILTER_LEN(FILTER_LEN)) u_sda_filter (
    .clk(link_clk),
    .rst_n(rst_n),
    .pin(bus.sda),
    .filt(sda_f)
  );

  logic scl_q_reg, sda_q_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  always_comb begin
    scl_rise = scl_f && !scl_q_reg;
    scl_fall = !scl_f && scl_q_reg;
    start_det = scl_f && scl_q_reg && sda_q_reg && !sda_f;
    stop_det = scl_f && scl_q_reg && !sda_q_reg && sda_f;
  end

  // ---------------------------------------------------------------
  // Protocol state
  // ---------------------------------------------------------------
  isb_tstate_type state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [6:0] wiper_reg, wiper_next;
  logic cmd_ok_reg, cmd_ok_next;
  logic rw_reg, rw_next;
  logic oe_reg, oe_next;
  logic nack_reg, nack_next;
  logic wr_reg, wr_next;
  logic coll_reg, coll_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    wiper_next = wiper_reg;
    cmd_ok_next = cmd_ok_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    nack_next = nack_reg;
    wr_next = 1'b0;
    coll_next = 1'b0;
    if (stop_det) begin
      // Stop ends everything; a byte cut short is never written
      state_next = ST_IDLE;
      oe_next = 1'b0;
      cnt_next = '0;
    end else if (start_det) begin
      // Start and repeated Start both restart address reception
      state_next = ST_ADDR;
      oe_next = 1'b0;
      cnt_next = '0;
    end else if (scl_rise && oe_reg && (state_reg == ST_TX ||
                 state_reg == ST_ADDR_ACK || state_reg == ST_CMD_ACK ||
                 state_reg == ST_DATA_ACK)) begin
      // We pull low here, nothing to compare; count the bit only in ST_TX
      if (state_reg == ST_TX) begin
        cnt_next = cnt_reg + 1'b1;
      end
    end else if (scl_rise && state_reg == ST_TX && !sda_f) begin
      // We released for a one but the line is low: another master
      // owns the bus, so drop out and wait for a fresh Start
      coll_next = 1'b1;
      state_next = ST_IGNORE;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_IGNORE: begin
          oe_next = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_f};
            cnt_next = cnt_reg + 1'b1;
          end else if (scl_fall && cnt_reg == 4'(isb_pkg::BYTE_BITS)) begin
            cnt_next = '0;
            oe_next = 1'b1;
            if (state_reg == ST_ADDR) begin
              rw_next = shift_reg[0];
              state_next = ST_ADDR_ACK;
              if (shift_reg[7:1] != TARGET_ADDR ||
                  shift_reg[7:1] == isb_pkg::ADDR_GENERAL_CALL) begin
                oe_next = 1'b0;
                state_next = ST_IGNORE;
              end
            end else if (state_reg == ST_CMD) begin
              // A nonzero command is acknowledged but blocks writes
              cmd_ok_next = (shift_reg == isb_pkg::CMD_WIPER);
              state_next = ST_CMD_ACK;
            end else begin
              // Data lands at the acknowledge, never earlier
              if (cmd_ok_reg) begin
                wiper_next = shift_reg[6:0];
                wr_next = 1'b1;
              end
              state_next = ST_DATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_CMD_ACK, ST_DATA_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            cnt_next = '0;
            if (state_reg == ST_ADDR_ACK && rw_reg) begin
              shift_next = {1'b0, wiper_reg};
              oe_next = 1'b1;
              state_next = ST_TX;
            end else if (state_reg == ST_ADDR_ACK) begin
              cmd_ok_next = 1'b0;
              state_next = ST_CMD;
            end else begin
              state_next = ST_WDATA;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 1'b1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'(isb_pkg::BYTE_BITS)) begin
              oe_next = 1'b0;
              cnt_next = '0;
              state_next = ST_MACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = !shift_reg[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nack_next = sda_f;
          end else if (scl_fall) begin
            if (nack_reg) begin
              // Master is done reading; hold off until a new Start
              state_next = ST_IGNORE;
            end else begin
              shift_next = {1'b0, wiper_reg};
              oe_next = 1'b1;
              state_next = ST_TX;
            end
          end
        end
        default: begin
          state_next = ST_IGNORE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      shift_reg <= '0;
      wiper_reg <= isb_pkg::WIPER_RESET;
      cmd_ok_reg <= 1'b0;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      wr_reg <= 1'b0;
      coll_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      wiper_reg <= wiper_next;
      cmd_ok_reg <= cmd_ok_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      nack_reg <= nack_next;
      wr_reg <= wr_next;
      coll_reg <= coll_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Only the data line is ever driven; the clock is input only
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = oe_reg;
  assign wiper = wiper_reg;
  assign wiper_wr = wr_reg;
  assign bus_collision = coll_reg;
  assign bus_active = (state_reg != ST_IDLE);
endmodule : isb_target

/* rtl/isb_master.sv */
// Master end: drives the bus clock and runs wiper write/read commands.
// Assumes one command at a time from the user side, on the system clock.
`timescale 1ns/1ps
module isb_master #(
  parameter int SCL_HZ = isb_pkg::SCL_FAST_HZ,
  parameter logic [6:0] TARGET_ADDR = isb_pkg::ADDR_MAIN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  isb_bus_if.master bus,
  // Command
  input wire logic req,
  input wire logic req_read,
  input wire logic [7:0] req_cmd,
  input wire logic [7:0] req_data,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [7:0] rd_data
);
  localparam int QTR = isb_pkg::CLK_HZ / (4 * SCL_HZ);
  localparam int QW = $clog2(QTR + 1);

  generate
    if (SCL_HZ > isb_pkg::SCL_FAST_HZ || QTR < 4) begin : g_bad_rate
      $error("SCL_HZ above fast mode or too fast for clk");
    end
  endgenerate

  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_START = 2'h1,
    MS_BYTE = 2'h3,
    MS_STOP = 2'h2
  } isb_mstate_type;

  // Byte sent in a segment; segment 5 of a read is received
  function automatic logic [7:0] seg_byte(input logic [2:0] seg,
                                         input logic [7:0] cmd,
                                         input logic [7:0] dat);
    unique case (seg)
      3'h1: seg_byte = {TARGET_ADDR, 1'b0};
      3'h2: seg_byte = cmd;
      3'h4: seg_byte = {TARGET_ADDR, 1'b1};
      default: seg_byte = dat;
    endcase
  endfunction : seg_byte

  isb_mstate_type st_reg, st_next;
  logic [QW-1:0] q_reg, q_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [2:0] seg_reg, seg_next;
  logic rd_reg, rd_next;
  logic [7:0] cmd_reg, cmd_next, dat_reg, dat_next, rx_reg, rx_next;
  logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic nack_reg, nack_next, done_reg, done_next;
  logic s1_reg, s2_reg;
  logic tick, rx_seg;
  logic [7:0] tx;

  always_comb begin
    tick = (q_reg == QW'(QTR - 1));
    rx_seg = rd_reg && seg_reg == 3'h5;
    tx = seg_byte(seg_reg, cmd_reg, dat_reg);
    st_next = st_reg;
    q_next = tick ? '0 : q_reg + 1'b1;
    ph_next = tick ? ph_reg + 2'h1 : ph_reg;
    bit_next = bit_reg;
    seg_next = seg_reg;
    rd_next = rd_reg;
    cmd_next = cmd_reg;
    dat_next = dat_reg;
    rx_next = rx_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    nack_next = nack_reg;
    done_next = 1'b0;
    unique case (st_reg)
      MS_IDLE: begin
        q_next = '0;
        ph_next = 2'h0;
        if (req) begin
          rd_next = req_read;
          cmd_next = req_cmd;
          dat_next = req_data;
          nack_next = 1'b0;
          seg_next = 3'h0;
          st_next = MS_START;
        end
      end
      MS_START: if (tick) begin
        unique case (ph_reg)
          2'h0: sda_oe_next = 1'b0;
          2'h1: scl_oe_next = 1'b0;
          2'h2: sda_oe_next = 1'b1;
          2'h3: begin
            scl_oe_next = 1'b1;
            bit_next = '0;
            seg_next = seg_reg + 3'h1;
            st_next = MS_BYTE;
          end
        endcase
      end
      MS_BYTE: if (tick) begin
        unique case (ph_reg)
          // Data moves only mid-way through the low half of the clock, one quarter after it falls
          2'h0: sda_oe_next = bit_reg < 4'h8 && !rx_seg &&
                              !tx[3'(4'h7 - bit_reg)];
          2'h1: scl_oe_next = 1'b0;
          2'h2: begin
            if (bit_reg < 4'h8) begin
              rx_next = {rx_reg[6:0], s2_reg};
            end else if (!rx_seg && s2_reg) begin
              nack_next = 1'b1;
            end
          end
          2'h3: begin
            scl_oe_next = 1'b1;
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h8) begin
              seg_next = seg_reg + 3'h1;
              if (nack_reg || rx_seg || (!rd_reg && seg_reg == 3'h3)) begin
                st_next = MS_STOP;
              end else if (rd_reg && seg_reg == 3'h2) begin
                st_next = MS_START;
              end
              bit_next = '0;
            end
          end
        endcase
      end
      MS_STOP: if (tick) begin
        unique case (ph_reg)
          2'h0: sda_oe_next = 1'b1;
          2'h1: scl_oe_next = 1'b0;
          2'h2: sda_oe_next = 1'b0;
          2'h3: begin
            done_next = 1'b1;
            st_next = MS_IDLE;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= MS_IDLE;
      q_reg <= '0;
      ph_reg <= 2'h0;
      bit_reg <= '0;
      seg_reg <= '0;
      rd_reg <= 1'b0;
      cmd_reg <= '0;
      dat_reg <= '0;
      rx_reg <= '0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      q_reg <= q_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      seg_reg <= seg_next;
      rd_reg <= rd_next;
      cmd_reg <= cmd_next;
      dat_reg <= dat_next;
      rx_reg <= rx_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      nack_reg <= nack_next;
      done_reg <= done_next;
      s1_reg <= bus.sda;
      s2_reg <= s1_reg;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_reg;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_reg;
  assign busy = (st_reg != MS_IDLE);
  assign done = done_reg;
  assign nack = nack_reg;
  assign rd_data = rx_reg;
endmodule : isb_master

/* verification/isb_bus_chk.sv */
// Checker for the main bus, watching the target end on the link clock.
// Assumes clean simulated levels and one target on the bus.
`timescale 1ns/1ps
module isb_bus_chk #(
  parameter logic [6:0] TARGET_ADDR = isb_pkg::ADDR_MAIN,
  parameter int FILTER_LEN = isb_pkg::SPIKE_CYCLES
) (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // Bus
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_o,
  input wire logic s_sda_oe
);
  // Filter, two sync flops and one register stage, with margin
  localparam int ACK_LAT = FILTER_LEN + 5;
  logic scl_reg, sda_reg, first_reg, first_next, rd_reg, rd_next;
  logic act_reg, act_next, scl_rise, scl_fall, start_ev, stop_ev;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;

  // ---------------------------------------------------------------
  // Bit and byte tracking
  // ---------------------------------------------------------------
  assign scl_rise = scl && !scl_reg;
  assign scl_fall = !scl && scl_reg;
  assign start_ev = scl && scl_reg && sda_reg && !sda;
  assign stop_ev = scl && scl_reg && !sda_reg && sda;

  always_comb begin
    cnt_next = cnt_reg;
    first_next = first_reg;
    rd_next = rd_reg;
    act_next = act_reg;
    sh_next = sh_reg;
    if (scl_rise) begin
      cnt_next = (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
      if (cnt_reg != 4'h8) sh_next = {sh_reg[6:0], sda};
      if (cnt_reg == 4'h8 && first_reg) begin
        first_next = 1'b0;
        rd_next = sh_reg[0];
      end
    end
    if (start_ev) begin
      cnt_next = 4'h0;
      first_next = 1'b1;
      rd_next = 1'b0;
      act_next = 1'b1;
    end
    if (stop_ev) act_next = 1'b0;
  end

  always_ff @(posedge link_clk) begin
    scl_reg <= rst_n ? scl : 1'b1;
    sda_reg <= rst_n ? sda : 1'b1;
    cnt_reg <= rst_n ? cnt_next : 4'h0;
    first_reg <= rst_n ? first_next : 1'b1;
    rd_reg <= rst_n ? rd_next : 1'b0;
    act_reg <= rst_n ? act_next : 1'b0;
    sh_reg <= rst_n ? sh_next : 8'h00;
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);

  oe_change_low_a: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("target moved data line with clock high");
  addr_ack_a: assert property (scl_rise && first_reg && cnt_reg == 4'h8
    && sh_reg[7:1] == TARGET_ADDR |-> !sda)
    else $error("matching address not acknowledged");
  data_ack_a: assert property (scl_rise && !first_reg && !rd_reg
    && cnt_reg == 4'h8 |-> !sda)
    else $error("written byte not acknowledged");
  read_msb_a: assert property (scl_rise && rd_reg && !first_reg
    && cnt_reg == 4'h0 |-> !sda)
    else $error("read byte top bit not zero");
  ack_release_a: assert property (scl_fall && cnt_reg == 4'h0 && !rd_reg
    |-> ##[1:ACK_LAT] !s_sda_oe)
    else $error("acknowledge not released in time");
  idle_quiet_a: assert property (!act_reg |-> !s_sda_oe)
    else $error("target drives data line while idle");
  no_drive_a: assert property (scl_rise && !rd_reg && cnt_reg != 4'h8
    |-> !s_sda_oe)
    else $error("target drives while master sends");
  rd_release_a: assert property (scl_rise && rd_reg && !first_reg
    && cnt_reg == 4'h8 |-> !s_sda_oe)
    else $error("target holds line in master ack slot");
  open_drain_a: assert property (s_sda_oe |-> !s_sda_o)
    else $error("target drives data line high");

  cover property (start_ev && act_reg);
  cover property (stop_ev);
  cover property (scl_rise && rd_reg && !first_reg);
endmodule : isb_bus_chk

/* verification/testbench.sv */
// Bench: master and target on the main bus; a second target on a fault
// bus driven by hand. Assumes design files and checker compiled first.
`timescale 1ns/1ps
module testbench;
  localparam int FL = 2;
  logic clk, link_clk, rst_n, req, req_read, busy, done, nack;
  logic [7:0] req_cmd, req_data, rd_data;
  logic [6:0] wiper, wiper2;
  logic wiper_wr, wiper_wr2, act, act2, coll, coll2, f_scl, f_sda;
  int failures, check_count, wr_n, wr_n2, coll_n, coll_m;
  isb_bus_if bus_m();
  isb_bus_if bus_f();

  assign bus_f.m_scl_o = 1'b0;
  assign bus_f.m_sda_o = 1'b0;
  assign bus_f.m_scl_oe = f_scl;
  assign bus_f.m_sda_oe = f_sda;

  isb_master isb_master_inst (.clk(clk), .rst_n(rst_n), .bus(bus_m.master),
    .req(req), .req_read(req_read), .req_cmd(req_cmd), .req_data(req_data),
    .busy(busy), .done(done), .nack(nack), .rd_data(rd_data));
  isb_target #(.FILTER_LEN(FL)) isb_target_inst (.link_clk(link_clk),
    .rst_n(rst_n), .bus(bus_m.target), .wiper(wiper), .wiper_wr(wiper_wr),
    .bus_active(act), .bus_collision(coll));
  isb_target #(.TARGET_ADDR(isb_pkg::ADDR_ALT), .FILTER_LEN(FL))
    isb_target_inst2 (.link_clk(link_clk), .rst_n(rst_n),
    .bus(bus_f.target), .wiper(wiper2), .wiper_wr(wiper_wr2),
    .bus_active(act2), .bus_collision(coll2));
  isb_bus_chk #(.FILTER_LEN(FL)) isb_bus_chk_inst (.link_clk(link_clk),
    .rst_n(rst_n), .scl(bus_m.scl), .sda(bus_m.sda),
    .s_sda_o(bus_m.s_sda_o), .s_sda_oe(bus_m.s_sda_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Odd offset keeps the link clock out of phase with the system clock
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  always @(posedge link_clk) begin
    if (wiper_wr === 1'b1) wr_n++;
    if (wiper_wr2 === 1'b1) wr_n2++;
    if (coll2 === 1'b1) coll_n++;
    if (coll === 1'b1) coll_m++;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic mop(input logic rd, input logic [7:0] cmd,
                     input logic [7:0] dat);
    int n;
    @(negedge clk);
    req = 1'b1;
    req_read = rd;
    req_cmd = cmd;
    req_data = dat;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 25000) begin
      @(negedge clk);
      n++;
    end
    chk(n < 25000 && busy === 1'b0, "master command never finished");
  endtask : mop

  // One quarter bit on the fault bus; 1 means pull the line low
  task automatic fq(input logic scl_pull, input logic sda_pull);
    f_scl = scl_pull;
    f_sda = sda_pull;
    repeat (24) @(negedge clk);
  endtask : fq

  task automatic f_start();
    fq(1'b1, 1'b0);
    fq(1'b0, 1'b0);
    fq(1'b0, 1'b1);
    fq(1'b1, 1'b1);
  endtask : f_start

  task automatic f_stop();
    fq(1'b1, 1'b1);
    fq(1'b0, 1'b1);
    fq(1'b0, 1'b0);
  endtask : f_stop

  task automatic f_bit(input logic b, output logic s);
    fq(1'b1, ~b);
    fq(1'b0, ~b);
    s = bus_f.sda;
    fq(1'b0, ~b);
    fq(1'b1, ~b);
  endtask : f_bit

  // Returns the eight sampled bits above the acknowledge slot
  task automatic f_byte(input logic [7:0] d, output logic [8:0] got);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      f_bit(d[i], s);
      got[i + 1] = s;
    end
    f_bit(1'b1, s);
    got[0] = s;
  endtask : f_byte

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_main();
    chk(wiper === isb_pkg::WIPER_RESET && act === 1'b0, "reset state");
    mop(1'b0, isb_pkg::CMD_WIPER, 8'hD5);
    chk(nack === 1'b0 && wiper === 7'h55, "write not applied");
    chk(wr_n == 1 && act === 1'b0, "write pulse or idle wrong");
    mop(1'b1, isb_pkg::CMD_WIPER, 8'h00);
    chk(nack === 1'b0 && rd_data === 8'h55, "read back wrong");
    mop(1'b0, 8'h01, 8'h12);
    chk(wiper === 7'h55 && wr_n == 1, "bad command wrote");
    chk(coll_m == 0, "collision on clean bus");
    $display("main bus test finished");
  endtask : t_main

  task automatic t_alt();
    logic [8:0] g;
    f_start();
    chk(act2 === 1'b1, "start not seen");
    f_byte({isb_pkg::ADDR_ALT, 1'b0}, g);
    chk(g[0] === 1'b0, "variant address not acked");
    f_byte(isb_pkg::CMD_WIPER, g);
    f_byte(8'h2A, g);
    chk(g[0] === 1'b0, "data not acked");
    f_stop();
    chk(wiper2 === 7'h2A && act2 === 1'b0, "write or stop wrong");
    f_sda = 1'b1;
    @(negedge clk);
    f_sda = 1'b0;
    repeat (10) @(negedge clk);
    chk(act2 === 1'b0, "spike taken as start");
    $display("variant address test finished");
  endtask : t_alt

  task automatic t_nack();
    logic [8:0] g;
    logic [6:0] adr [2];
    adr = '{isb_pkg::ADDR_MAIN, isb_pkg::ADDR_GENERAL_CALL};
    foreach (adr[k]) begin
      f_start();
      f_byte({adr[k], 1'b0}, g);
      chk(g[0] === 1'b1, "foreign address acked");
      f_byte(isb_pkg::CMD_WIPER, g);
      chk(g[0] === 1'b1, "ignored transfer acked");
      f_byte(8'h01, g);
      f_stop();
    end
    chk(wiper2 === 7'h2A && wr_n2 == 1, "ignored transfer wrote");
    $display("refused address test finished");
  endtask : t_nack

  task automatic t_abort();
    logic [8:0] g;
    logic s;
    for (int k = 0; k < 2; k++) begin
      f_start();
      f_byte({isb_pkg::ADDR_ALT, 1'b0}, g);
      f_byte(isb_pkg::CMD_WIPER, g);
      f_bit(1'b1, s);
      f_bit(1'b0, s);
      f_bit(1'b1, s);
      if (k == 0) f_stop();
      chk(wiper2 === 7'h2A && wr_n2 == 1, "aborted byte wrote");
    end
    f_start();
    f_byte({isb_pkg::ADDR_ALT, 1'b0}, g);
    f_byte(isb_pkg::CMD_WIPER, g);
    f_byte(8'h7F, g);
    f_stop();
    chk(wiper2 === 7'h7F && wr_n2 == 2, "write after restart lost");
    $display("abort test finished");
  endtask : t_abort

  task automatic t_coll();
    logic [8:0] g;
    logic s;
    f_start();
    f_byte({isb_pkg::ADDR_ALT, 1'b0}, g);
    f_byte(isb_pkg::CMD_WIPER, g);
    f_start();
    f_byte({isb_pkg::ADDR_ALT, 1'b1}, g);
    chk(g[0] === 1'b0, "read address not acked");
    f_bit(1'b1, s);
    chk(s === 1'b0, "read top bit not zero");
    f_bit(1'b0, s);
    chk(coll_n == 1, "collision not flagged");
    f_bit(1'b1, s);
    chk(s === 1'b1, "target still drives after collision");
    f_stop();
    $display("collision test finished");
  endtask : t_coll

  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    req_read = 1'b0;
    req_cmd = 8'h00;
    req_data = 8'h00;
    f_scl = 1'b0;
    f_sda = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    t_main();
    t_alt();
    t_nack();
    t_abort();
    t_coll();
    test_done();
  end

  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : testbench
